/* File: adcc_control.sv */
// converter control, status, trigger and result registers behind the 8-bit cpu bus
// What this block does
// - result top 8 bits go to high byte, low 2 bits to low byte bits 7:6.
// - result register bits 5 to 0 always read zero.
// - reset or standby clears all four result registers.
// - inputs 0/4 to A, 1/5 to B, 2/6 to C, 3/7 to D.
// - control/status clears to zero on reset or standby.
// - end flag sets after single conversion, or after all scanned channels finish.
// - end flag clears by writing 0 after reading 1; writing 1 does nothing.
// - interrupt request equals end flag when interrupt enable is one.
// - start bit begins conversion; single mode clears it when done.
// - scan mode cycles until start is cleared by software, reset or standby.
// - external trigger pin may also set the start bit when enabled.
// - mode bit zero selects single, one selects scan.
// - time select picks 266 or 134 states, doubled at half peripheral clock.
// - group bit plus index n: single converts n, scan converts 0 through n.
// - trigger enable bit gates external trigger; software start always works.
// - trigger control resets to 0x7f on reset or standby.
// - trigger control bits 6 to 0 ignore writes and read one.
// - high byte read returns it and copies low byte into holding latch.
// - low byte read returns holding latch contents.
// - enabled falling edge on trigger pin sets start, like a software start.
// - each scan start begins at the group's first channel.
// - follow-on scan conversions take 256 or 128 states.
`timescale 1ns/10ps
`default_nettype none
module adcc_control
    import adcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic periph_half,
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic ext_trigger_n,
    input wire logic [RESULT_BITS-1:0] ana_result,
    output logic [2:0] ana_channel,
    output logic ana_sample,
    output logic conv_busy,
    output logic conv_end_irq
);
    // =====================================================================
    // decode
    logic clr;
    logic sel_result;
    logic sel_ctrl;
    logic sel_trig;
    logic [1:0] res_idx;
    logic wr_ctrl;
    logic rd_ctrl;

    // standby behaves like reset for every register here
    assign clr = rst | standby;
    assign sel_result = (bus_addr >= ADDR_RESULT_A_HI) && (bus_addr <= ADDR_RESULT_D_LO);
    assign sel_ctrl = (bus_addr == ADDR_CTRL_STATUS);
    assign sel_trig = (bus_addr == ADDR_TRIG_CTRL);
    assign res_idx = bus_addr[2:1];
    assign wr_ctrl = bus_wr && sel_ctrl;
    assign rd_ctrl = bus_rd && sel_ctrl;

    // =====================================================================
    // control register state
    logic end_flag_r;
    logic clear_armed_r;
    logic irq_en_r;
    logic start_r;
    logic scan_r;
    logic time_sel_r;
    logic group_r;
    logic [1:0] chan_idx_r;
    logic trig_en_r;
    logic trig_prev_r;
    logic [15:0] result_r [4];
    logic [7:0] temp_r;
    adcc_state_t state_r;
    logic [1:0] cur_chan_r;
    logic first_conv_r;

    logic conv_done;
    logic trig_fall;
    logic last_chan;
    logic launch;
    logic abort;
    logic flag_set;
    logic start_hw_clear;

    // falling edge on the trigger pin, only when enabled
    assign trig_fall = trig_en_r && trig_prev_r && !ext_trigger_n;
    assign last_chan = !scan_r || (cur_chan_r == chan_idx_r);
    // flag sets at the end of a single conversion or of the last scanned channel
    assign flag_set = conv_done && last_chan;
    assign start_hw_clear = conv_done && !scan_r;
    // a cleared start bit stops any conversion in progress
    assign abort = (state_r == ADCC_CONVERT) && !start_r;
    assign launch = (state_r == ADCC_IDLE) && start_r;

    always_ff @(posedge clock) begin
        if (clr) begin
            trig_prev_r <= 1'b1;
        end else begin
            trig_prev_r <= ext_trigger_n;
        end
    end

    // =====================================================================
    // conv_control_status
    always_ff @(posedge clock) begin
        if (clr) begin
            irq_en_r <= CTRL_STATUS_RESET[BIT_IRQ_EN];
            scan_r <= CTRL_STATUS_RESET[BIT_SCAN];
            time_sel_r <= CTRL_STATUS_RESET[BIT_TIME_SEL];
            group_r <= CTRL_STATUS_RESET[BIT_GROUP];
            chan_idx_r <= CTRL_STATUS_RESET[1:0];
        end else if (wr_ctrl) begin
            irq_en_r <= bus_wdata[BIT_IRQ_EN];
            scan_r <= bus_wdata[BIT_SCAN];
            time_sel_r <= bus_wdata[BIT_TIME_SEL];
            group_r <= bus_wdata[BIT_GROUP];
            chan_idx_r <= bus_wdata[1:0];
        end
    end

    // start bit: software write, trigger pin, cleared by hardware in single mode
    always_ff @(posedge clock) begin
        if (clr) begin
            start_r <= CTRL_STATUS_RESET[BIT_START];
        end else if (trig_fall) begin
            start_r <= 1'b1;
        end else if (wr_ctrl) begin
            start_r <= bus_wdata[BIT_START];
        end else if (start_hw_clear) begin
            start_r <= 1'b0;
        end
    end

    // end flag: hardware set wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (clr) begin
            end_flag_r <= CTRL_STATUS_RESET[BIT_END_FLAG];
            clear_armed_r <= 1'b0;
        end else begin
            if (flag_set) begin
                end_flag_r <= 1'b1;
            end else if (wr_ctrl && !bus_wdata[BIT_END_FLAG] && clear_armed_r) begin
                end_flag_r <= 1'b0;
            end
            // a read that returns one arms the clear; any control/status write disarms it
            if (rd_ctrl && end_flag_r) begin
                clear_armed_r <= 1'b1;
            end else if (wr_ctrl) begin
                clear_armed_r <= 1'b0;
            end
        end
    end

    assign conv_end_irq = end_flag_r && irq_en_r;

    // =====================================================================
    // trigger_control
    always_ff @(posedge clock) begin
        if (clr) begin
            trig_en_r <= TRIG_CTRL_RESET[BIT_TRIG_EN];
        end else if (bus_wr && sel_trig) begin
            trig_en_r <= bus_wdata[BIT_TRIG_EN];
        end
    end

    // =====================================================================
    // conversion sequencer
    always_ff @(posedge clock) begin
        if (clr) begin
            state_r <= ADCC_IDLE;
            cur_chan_r <= 2'h0;
            first_conv_r <= 1'b1;
        end else begin
            case (state_r)
                ADCC_IDLE: begin
                    if (launch) begin
                        state_r <= ADCC_CONVERT;
                        // scan always restarts at the group's first input
                        cur_chan_r <= scan_r ? 2'h0 : chan_idx_r;
                        first_conv_r <= 1'b1;
                    end
                end
                ADCC_CONVERT: begin
                    if (abort) begin
                        state_r <= ADCC_IDLE;
                    end else if (conv_done) begin
                        if (!scan_r) begin
                            state_r <= ADCC_IDLE;
                        end else begin
                            // scan wraps back to channel 0 of the group
                            cur_chan_r <= last_chan ? 2'h0 : cur_chan_r + 2'h1;
                            first_conv_r <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_r <= ADCC_IDLE;
                end
            endcase
        end
    end

    // one sample pulse per conversion; follow-on scan conversions start on done
    always_ff @(posedge clock) begin
        if (clr) begin
            ana_sample <= 1'b0;
            ana_channel <= 3'h0;
        end else begin
            ana_sample <= launch || (conv_done && scan_r && !abort);
            if (launch) begin
                ana_channel <= {group_r, (scan_r ? 2'h0 : chan_idx_r)};
            end else if (conv_done && scan_r) begin
                ana_channel <= {group_r, (last_chan ? 2'h0 : cur_chan_r + 2'h1)};
            end
        end
    end

    assign conv_busy = (state_r == ADCC_CONVERT);

    adcc_conv_timer u_timer (
        .clock(clock),
        .rst(clr),
        .launch(launch || (conv_done && scan_r)),
        .abort(abort),
        .first_conv(launch ? 1'b1 : 1'b0),
        .time_fast(time_sel_r),
        .periph_half(periph_half),
        .done(conv_done)
    );

    // =====================================================================
    // result registers, one per position in the group
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_result
            always_ff @(posedge clock) begin
                if (clr) begin
                    result_r[gi] <= RESULT_RESET;
                end else if (conv_done && (cur_chan_r == 2'(gi))) begin
                    // both groups share a register by position pad bits stay zero
                    result_r[gi] <= {ana_result, RESULT_LOW_PAD};
                end
            end
        end
    endgenerate

    // =====================================================================
    // read path with the low-byte holding latch
    always_ff @(posedge clock) begin
        if (clr) begin
            temp_r <= 8'h00;
        end else if (bus_rd && sel_result && !bus_addr[0]) begin
            temp_r <= result_r[res_idx][7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (clr) begin
            bus_rdata <= UNMAPPED_READ;
        end else if (bus_rd) begin
            if (sel_result) begin
                // low byte comes from the latch, so read high first for a coherent pair
                bus_rdata <= bus_addr[0] ? temp_r : result_r[res_idx][15:8];
            end else if (sel_ctrl) begin
                bus_rdata <= {end_flag_r, irq_en_r, start_r, scan_r, time_sel_r, group_r, chan_idx_r};
            end else if (sel_trig) begin
                bus_rdata <= {trig_en_r, TRIG_CTRL_FIXED};
            end else begin
                bus_rdata <= UNMAPPED_READ;
            end
        end
    end
endmodule // adcc_control
`default_nettype wire

/* File: adcc_pkg.sv */
// shared constants for the converter control and result register block
`default_nettype none
package adcc_pkg;
    // =====================================================================
    // register addresses on the 8-bit internal bus
    localparam logic [15:0] ADDR_RESULT_A_HI = 16'hffe0;
    localparam logic [15:0] ADDR_RESULT_D_LO = 16'hffe7;
    localparam logic [15:0] ADDR_CTRL_STATUS = 16'hffe8;
    localparam logic [15:0] ADDR_TRIG_CTRL = 16'hffe9;
    // =====================================================================
    // conv_control_status fields
    localparam int BIT_END_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_START = 5;
    localparam int BIT_SCAN = 4;
    localparam int BIT_TIME_SEL = 3;
    localparam int BIT_GROUP = 2;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    // =====================================================================
    // trigger_control fields
    localparam int BIT_TRIG_EN = 7;
    localparam logic [7:0] TRIG_CTRL_RESET = 8'h7f;
    localparam logic [6:0] TRIG_CTRL_FIXED = 7'h7f;
    // =====================================================================
    // result layout and reset
    localparam int RESULT_BITS = 10;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [5:0] RESULT_LOW_PAD = 6'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // =====================================================================
    // conversion times in states (one state is one system clock)
    localparam int FIRST_STATES_SLOW = 266;
    localparam int FIRST_STATES_FAST = 134;
    localparam int SCAN_STATES_SLOW = 256;
    localparam int SCAN_STATES_FAST = 128;
    localparam int STATE_NS = 8;
    localparam int CLOCK_NS = 8;
    localparam int CYCLES_PER_STATE = (STATE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int CONV_CNT_W = 11;
    typedef enum logic {
        ADCC_IDLE,
        ADCC_CONVERT
    } adcc_state_t;
endpackage
`default_nettype wire

/* File: adcc_conv_timer.sv */
// conversion length timer: counts one conversion and pulses when it ends
`timescale 1ns/10ps
`default_nettype none
module adcc_conv_timer
    import adcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic launch,
    input wire logic abort,
    input wire logic first_conv,
    input wire logic time_fast,
    input wire logic periph_half,
    output logic done
);
    // =====================================================================
    // length selection
    localparam logic [CONV_CNT_W-1:0] LEN_FIRST_SLOW = CONV_CNT_W'(FIRST_STATES_SLOW * CYCLES_PER_STATE);
    localparam logic [CONV_CNT_W-1:0] LEN_FIRST_FAST = CONV_CNT_W'(FIRST_STATES_FAST * CYCLES_PER_STATE);
    localparam logic [CONV_CNT_W-1:0] LEN_SCAN_SLOW = CONV_CNT_W'(SCAN_STATES_SLOW * CYCLES_PER_STATE);
    localparam logic [CONV_CNT_W-1:0] LEN_SCAN_FAST = CONV_CNT_W'(SCAN_STATES_FAST * CYCLES_PER_STATE);

    logic [CONV_CNT_W-1:0] len;
    logic [CONV_CNT_W-1:0] count_r;
    logic running_r;

    always_comb begin
        // the first conversion takes longer; follow-on scans use the shorter 256 or 128 state lengths
        if (first_conv) begin
            len = time_fast ? LEN_FIRST_FAST : LEN_FIRST_SLOW;
        end else begin
            len = time_fast ? LEN_SCAN_FAST : LEN_SCAN_SLOW;
        end
        if (periph_half) begin
            len = {len[CONV_CNT_W-2:0], 1'b0};
        end
    end

    // =====================================================================
    // counter
    always_ff @(posedge clock) begin
        if (rst || abort) begin
            running_r <= 1'b0;
            count_r <= '0;
        end else if (launch) begin
            running_r <= 1'b1;
            // the launch cycle after the start bit already counts, so a first conversion stays within its maximum
            count_r <= len - (first_conv ? CONV_CNT_W'(2) : CONV_CNT_W'(1));
        end else if (running_r) begin
            if (count_r == '0) begin
                running_r <= 1'b0;
            end else begin
                count_r <= count_r - CONV_CNT_W'(1);
            end
        end
    end

    assign done = running_r && (count_r == '0) && !abort;
endmodule // adcc_conv_timer
`default_nettype wire

/* File: adcc_control_sva.sv */
// assertion checker for the converter control block ports
`timescale 1ns/10ps
`default_nettype none
module adcc_control_sva
    import adcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic periph_half,
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic ext_trigger_n,
    input wire logic [RESULT_BITS-1:0] ana_result,
    input wire logic [2:0] ana_channel,
    input wire logic ana_sample,
    input wire logic conv_busy,
    input wire logic conv_end_irq
);
    // =====================================================================
    // shadows of mode bits, taken from bus writes
    logic scan_r;
    logic fast_r;
    logic trg_r;
    wire logic ctl_wr = bus_wr && bus_addr == ADDR_CTRL_STATUS;
    always_ff @(posedge clock) begin
        if (rst || standby) begin
            scan_r <= 1'b0;
            fast_r <= 1'b0;
        end else if (ctl_wr) begin
            scan_r <= bus_wdata[BIT_SCAN];
            fast_r <= bus_wdata[BIT_TIME_SEL];
        end
    end
    always_ff @(posedge clock) begin
        if (rst || standby) begin
            trg_r <= 1'b0;
        end else if (bus_wr && bus_addr == ADDR_TRIG_CTRL) begin
            trg_r <= bus_wdata[BIT_TRIG_EN];
        end
    end
    // =====================================================================
    // properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst || standby);
    sequence s_go;
        ctl_wr && bus_wdata[BIT_START] && !conv_busy ##1 !standby;
    endsequence
    sequence s_slow_single;
        ana_sample && !scan_r && !fast_r && !periph_half;
    endsequence
    a_sw_start: assert property (s_go |-> ##1 (ana_sample && conv_busy)) else $error("start not launched");
    a_slow_len: assert property (s_slow_single |-> ##264 conv_busy ##1 !conv_busy) else $error("slow length");
    a_fast_len: assert property (ana_sample && !scan_r && fast_r && !periph_half |-> ##132 conv_busy ##1 !conv_busy)
        else $error("fast length");
    a_trig_start: assert property ($fell(ext_trigger_n) && trg_r && !conv_busy && !bus_wr |-> ##2 ana_sample)
        else $error("trigger did not start");
    a_irq_off: assert property (ctl_wr && !bus_wdata[BIT_IRQ_EN] |=> !conv_end_irq) else $error("irq not masked");
    a_irq_cause: assert property ($rose(conv_end_irq) |-> $past(conv_busy) || $past(ctl_wr))
        else $error("irq rose without cause");
    a_trig_ones: assert property (bus_rd && bus_addr == ADDR_TRIG_CTRL |=> bus_rdata[6:0] == TRIG_CTRL_FIXED)
        else $error("trigger pad bits");
    a_low_pad: assert property (bus_rd && bus_addr[0] && bus_addr <= ADDR_RESULT_D_LO && bus_addr >= ADDR_RESULT_A_HI
        |=> bus_rdata[5:0] == RESULT_LOW_PAD) else $error("low pad bits");
    a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("read data moved");
    a_chan_hold: assert property (conv_busy && !ana_sample && $past(conv_busy) |-> $stable(ana_channel))
        else $error("channel moved mid conversion");
    a_standby_clr: assert property (disable iff (rst) standby |=> bus_rdata == 8'h00 && !conv_busy && !conv_end_irq
        && !ana_sample && ana_channel == 3'h0) else $error("standby did not clear");
endmodule // adcc_control_sva
bind adcc_control adcc_control_sva u_sva (.clock(clock), .rst(rst), .standby(standby), .periph_half(periph_half),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .ext_trigger_n(ext_trigger_n), .ana_result(ana_result), .ana_channel(ana_channel), .ana_sample(ana_sample),
    .conv_busy(conv_busy), .conv_end_irq(conv_end_irq));
`default_nettype wire

/* File: adcc_ana_model.sv */
// analog core stand-in: answers each conversion with a value built from the channel
`timescale 1ns/10ps
`default_nettype none
module adcc_ana_model (
    input wire logic clock,
    input wire logic [2:0] ana_channel,
    input wire logic ana_sample,
    input wire logic conv_busy,
    input wire logic [9:0] base,
    output logic [9:0] ana_result
);
    logic [2:0] chan_r;
    always_ff @(posedge clock) begin
        if (ana_sample) begin
            chan_r <= ana_channel;
        end
    end
    // idle output is inverted so a capture outside a conversion shows up
    assign ana_result = conv_busy ? (base ^ {chan_r, 7'h00}) : ~base;
endmodule // adcc_ana_model
`default_nettype wire

/* File: adcc_control_bench.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_control_bench;
    import adcc_pkg::*;
    logic clock, rst, standby, periph_half, bus_rd, bus_wr, ext_trigger_n, ana_sample, conv_busy, conv_end_irq;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, rd_v, cv;
    logic [9:0] ana_result, base;
    logic [2:0] ana_channel;
    logic [31:0] rv;
    logic [9:0] exp_res [4];
    integer n_fail, n_checks, seed, cyc, ch;
    adcc_control u_dut (.clock(clock), .rst(rst), .standby(standby), .periph_half(periph_half), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_trigger_n(ext_trigger_n),
        .ana_result(ana_result), .ana_channel(ana_channel), .ana_sample(ana_sample), .conv_busy(conv_busy),
        .conv_end_irq(conv_end_irq));
    adcc_ana_model u_ana (.clock(clock), .ana_channel(ana_channel), .ana_sample(ana_sample), .conv_busy(conv_busy),
        .base(base), .ana_result(ana_result));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // =====================================================================
    // bus and checking tasks
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 rd_v = bus_rdata;
    endtask
    task automatic chk_res(input int i);
        rd(ADDR_RESULT_A_HI + 16'(2 * i));
        check(rd_v, exp_res[i][9:2]);
        rd(ADDR_RESULT_A_HI + 16'(2 * i + 1));
        check(rd_v, {exp_res[i][1:0], 6'h00});
    endtask
    task automatic chk_reset;
        for (int a = 0; a < 11; a++) begin
            rd(ADDR_RESULT_A_HI + 16'(a));
            check(rd_v, a == 9 ? TRIG_CTRL_RESET : 8'h00);
        end
    endtask
    // waits for the end of a conversion, or for the interrupt, and checks the cycle count
    task automatic wait_for(input logic on_irq, input integer exp_n);
        cyc = 0;
        do begin
            @(posedge clock);
            #1 cyc = cyc + 1;
        end while ((on_irq ? conv_end_irq !== 1'b1 : (conv_busy === 1'b1 || cyc < 3)) && cyc < 1500);
        if (cyc >= 1500) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
        check(16'(cyc), 16'(exp_n));
    endtask
    task automatic new_base;
        rv = $random(seed);
        base <= rv[9:0];
    endtask
    // =====================================================================
    // main sequence
    initial begin
        seed = 32'h72e0e5b0;
        n_fail = 0;
        n_checks = 0;
        rst = 1'b1;
        standby = 1'b0;
        periph_half = 1'b0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        ext_trigger_n = 1'b1;
        base = 10'h000;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        chk_reset();
        wr(ADDR_TRIG_CTRL, 8'h00);
        wr(ADDR_RESULT_A_HI, 8'hff);
        rd(ADDR_RESULT_A_HI);
        check(rd_v, 8'h00);
        for (ch = 0; ch < 8; ch++) begin
            periph_half <= (ch == 7);
            new_base();
            exp_res[ch % 4] = rv[9:0] ^ {ch[2:0], 7'h00};
            cv = 8'h60 | {4'h0, ch[0], ch[2:0]};
            wr(ADDR_CTRL_STATUS, cv);
            wait_for(1'b0, (ch[0] ? 134 : 266) * (ch == 7 ? 2 : 1));
            check(conv_end_irq, 1'b1);
            cv = cv ^ 8'ha0;
            rd(ADDR_CTRL_STATUS);
            check(rd_v, cv);
            chk_res(ch % 4);
            wr(ADDR_CTRL_STATUS, cv);
            wr(ADDR_CTRL_STATUS, cv & 8'h7f);
            rd(ADDR_CTRL_STATUS);
            check(rd_v, cv);
            wr(ADDR_CTRL_STATUS, cv & 8'h7f);
            rd(ADDR_CTRL_STATUS);
            check({conv_end_irq, rd_v}, {1'b0, cv & 8'h7f});
        end
        rd(ADDR_RESULT_A_HI + 16'h6);
        rd(ADDR_RESULT_A_HI + 16'h1);
        check(rd_v, {exp_res[3][1:0], 6'h00});
        periph_half <= 1'b0;
        new_base();
        for (ch = 0; ch < 3; ch++) exp_res[ch] = rv[9:0] ^ {3'(ch + 4), 7'h00};
        wr(ADDR_CTRL_STATUS, 8'h7e);
        wait_for(1'b1, 390);
        rd(ADDR_CTRL_STATUS);
        check({conv_busy, rd_v}, 9'h1fe);
        wr(ADDR_CTRL_STATUS, 8'h5e);
        @(posedge clock);
        #1 check(conv_busy, 1'b0);
        for (ch = 0; ch < 3; ch++) chk_res(ch);
        wr(ADDR_TRIG_CTRL, 8'h80);
        rd(ADDR_TRIG_CTRL);
        check(rd_v, 8'hff);
        wr(ADDR_CTRL_STATUS, 8'h03);
        new_base();
        exp_res[3] = rv[9:0] ^ 10'h180;
        @(posedge clock);
        ext_trigger_n <= 1'b0;
        wait_for(1'b0, 267);
        ext_trigger_n <= 1'b1;
        chk_res(3);
        wr(ADDR_TRIG_CTRL, 8'h00);
        ext_trigger_n <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check(conv_busy, 1'b0);
        ext_trigger_n <= 1'b1;
        wr(ADDR_CTRL_STATUS, 8'h7c);
        wr(ADDR_TRIG_CTRL, 8'h80);
        standby <= 1'b1;
        repeat (3) @(posedge clock);
        standby <= 1'b0;
        chk_reset();
        report_and_stop();
    end
endmodule // adcc_control_bench
`default_nettype wire
